// File: verilog/tgcr_pkg.sv
package tgcr_pkg;
    // ==================================================
    // serial frame layout
    localparam int          FRAME_BITS  = 16;
    localparam int          INSTR_BITS  = 8;
    localparam logic [4:0]  FRAME_END   = 5'h10;
    localparam logic [4:0]  DATA_START  = 5'h08;
    localparam logic [2:0]  IDX_TOP     = 3'h7;
    localparam int          BIT_RW      = 7;

    // ==================================================
    // register offsets
    localparam logic [6:0]  OFS_GENERAL = 7'h00;
    localparam logic [6:0]  OFS_CLOCK   = 7'h01;
    localparam logic [6:0]  OFS_POWER   = 7'h02;

    // ==================================================
    // field positions
    localparam int          BIT_SHARED_LINE  = 7;
    localparam int          BIT_LSB_FIRST    = 6;
    localparam int          BIT_SOFT_RESET   = 5;
    localparam int          SCHEME_MSB       = 7;
    localparam int          SCHEME_LSB       = 5;
    localparam int          BIT_SECOND_CLK   = 2;
    localparam int          BIT_THIRD_INV    = 1;
    localparam int          TXPD_MSB         = 7;
    localparam int          TXPD_LSB         = 5;

    // ==================================================
    // reset values and writable masks
    localparam logic [7:0]  RST_GENERAL   = 8'h00;
    localparam logic [7:0]  RST_CLOCK     = 8'h00;
    localparam logic [7:0]  RST_POWER     = 8'h00;
    localparam logic [7:0]  WMASK_GENERAL = 8'hC0;
    localparam logic [7:0]  WMASK_CLOCK   = 8'hE6;
    localparam logic [7:0]  WMASK_POWER   = 8'hFF;

    // ==================================================
    // clocking schemes
    typedef enum logic [2:0] {
        SCHEME_STANDARD    = 3'b000,
        SCHEME_ALT_DUPLEX  = 3'b001,
        SCHEME_ALT_HD_WIDE = 3'b011,
        SCHEME_ALT_HD_NARR = 3'b101,
        SCHEME_CLONE       = 3'b111
    } tgcr_scheme_t;

    // ==================================================
    // transmit analog power-down codes
    localparam logic [2:0]  TXPD_A_ONLY = 3'b100;
    localparam logic [2:0]  TXPD_B_ONLY = 3'b010;
    localparam logic [2:0]  TXPD_BOTH   = 3'b111;
endpackage : tgcr_pkg

// File: verilog/tgcr_sync.sv
`timescale 1ns/1ps
module tgcr_sync (
    input  wire logic CLK_I,
    input  wire logic RST_I,
    input  wire logic async_i,
    output logic      sync_o
);
    typedef struct packed {
        logic meta;
        logic sync;
    } tgcr_sync_t;

    tgcr_sync_t state;
    tgcr_sync_t next_state;

    always_comb begin
        next_state      = state;
        next_state.meta = async_i;
        next_state.sync = state.meta;
        if (RST_I) begin
            next_state = '0;
        end
    end

    always_ff @(posedge CLK_I) begin
        state <= next_state;
    end

    assign sync_o = state.sync;
endmodule : tgcr_sync

// File: verilog/tgcr_top.sv
`timescale 1ns/1ps
// How it works
// - bit 7 of the general register, default 0, moves serial data to one shared two-way line.
// - bit 6 of the general register, default 0, shifts serial transfers lsb first when set.
// - a one written to bit 5 of the general register restores all defaults and relocks the pll.
// - the soft reset bit is never stored, so it always reads back as zero.
// - the clock scheme field resets to 000 (standard) and 111 selects clone mode.
// - scheme codes 001, 011, 101 pick the alternate timings; writes of 010, 100, 110 keep the old scheme field but store the other bits.
// - bit 2 of the clock register turns the second port pin into a clock output.
// - that second pin clock is inverted while the port runs full duplex.
// - bit 1 of the clock register inverts the clock on the third port pin.
// - power field 100 stops output A, 010 output B, 111 both plus support circuits.
// - the converter bias stays enabled under every transmit power-down option.
module tgcr_top
    import tgcr_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    input  wire logic       SCLK_I,
    input  wire logic       SEN_N_I,
    input  wire logic       SDIO_I,
    output logic            SDIO_O,
    output logic            SDIO_OE_O,
    output logic            SERIAL_DATA_OUT_PIN_O,
    output logic            SERIAL_DATA_OUT_PIN_OE_O,
    input  wire logic       FULL_DUPLEX_I,
    output logic [2:0]      CLK_SCHEME_O,
    output logic            SECOND_PIN_CLK_EN_O,
    output logic            SECOND_PIN_CLK_INV_O,
    output logic            THIRD_PIN_CLK_INV_O,
    output logic            TX_A_OUT_OFF_O,
    output logic            TX_B_OUT_OFF_O,
    output logic            TX_SUPPORT_OFF_O,
    output logic            DAC_BIAS_ON_O,
    output logic            PLL_RELOCK_O
);
    // ==================================================
    // serial clock domain: frame shifter
    typedef struct packed {
        logic [4:0] cnt;
        logic [7:0] instr;
        logic [7:0] data;
    } tgcr_frame_t;

    typedef struct packed {
        logic [7:0] gen;
        logic [7:0] clk;
        logic [7:0] pwr;
        logic       commit_tgl;
        logic       sr_tgl;
    } tgcr_cfg_t;

    typedef struct packed {
        logic sdio;
        logic sdio_oe;
        logic ser_out;
        logic ser_out_oe;
    } tgcr_drv_t;

    typedef struct packed {
        logic       commit_seen;
        logic       sr_seen;
        logic [7:0] clk;
        logic [7:0] pwr;
        logic [2:0] scheme;
        logic       en2;
        logic       inv2;
        logic       inv3;
        logic       a_off;
        logic       b_off;
        logic       sup_off;
        logic       bias_on;
        logic       relock;
    } tgcr_core_t;

    tgcr_frame_t frame;
    tgcr_frame_t next_frame;
    tgcr_cfg_t   cfg;
    tgcr_cfg_t   next_cfg;
    tgcr_drv_t   drv;
    tgcr_drv_t   next_drv;
    tgcr_core_t  core;
    tgcr_core_t  next_core;

    logic        lsb_first;
    logic        shared_line;
    logic [2:0]  bit_idx;
    logic        write_fire;
    logic [7:0]  wdata;
    logic        commit_sync;
    logic        sr_sync;

    function automatic logic [7:0] read_reg(input logic [6:0] addr, input tgcr_cfg_t c);
        logic [7:0] r;
        r = 8'h00;
        unique case (addr)
            OFS_GENERAL: r = c.gen & WMASK_GENERAL;
            OFS_CLOCK:   r = c.clk & WMASK_CLOCK;
            OFS_POWER:   r = c.pwr & WMASK_POWER;
            default:     r = 8'h00;
        endcase
        return r;
    endfunction : read_reg

    // codes 010, 100 and 110 are unused
    function automatic logic scheme_legal(input logic [2:0] code);
        return (code == SCHEME_STANDARD) || (code == SCHEME_ALT_DUPLEX)
            || (code == SCHEME_ALT_HD_WIDE) || (code == SCHEME_ALT_HD_NARR)
            || (code == SCHEME_CLONE);
    endfunction : scheme_legal

    assign shared_line = cfg.gen[BIT_SHARED_LINE];
    assign lsb_first   = cfg.gen[BIT_LSB_FIRST];
    assign bit_idx     = lsb_first ? frame.cnt[2:0] : IDX_TOP - frame.cnt[2:0];

    // ==================================================
    // frame phases
    logic        instr_phase;
    logic        data_phase;
    logic        read_phase;
    logic        last_edge;
    logic [2:0]  wr_scheme;

    assign instr_phase = frame.cnt < DATA_START;
    assign data_phase  = !instr_phase && (frame.cnt < FRAME_END);
    assign read_phase  = frame.instr[BIT_RW] && data_phase;
    assign last_edge   = frame.cnt == (FRAME_END - 5'h01);
    assign wr_scheme   = wdata[SCHEME_MSB:SCHEME_LSB];

    always_comb begin
        next_frame = frame;
        wdata      = frame.data;
        write_fire = 1'b0;
        if (frame.cnt < FRAME_END) begin
            next_frame.cnt = frame.cnt + 5'h01;
        end
        if (instr_phase) begin
            next_frame.instr[bit_idx] = SDIO_I;
        end else if (data_phase) begin
            next_frame.data[bit_idx] = SDIO_I;
            wdata[bit_idx]           = SDIO_I;
        end
        if (last_edge && !frame.instr[BIT_RW]) begin
            write_fire = 1'b1;
        end
    end

    // deselect clears the count, so a cut frame never writes
    always_ff @(posedge SCLK_I or posedge SEN_N_I) begin
        if (SEN_N_I) begin
            frame <= '0;
        end else begin
            frame <= next_frame;
        end
    end

    // ==================================================
    // serial clock domain: register storage
    always_comb begin
        next_cfg = cfg;
        if (write_fire) begin
            unique case (frame.instr[6:0])
                OFS_GENERAL: begin
                    // soft reset bit is acted on, never stored
                    if (wdata[BIT_SOFT_RESET]) begin
                        next_cfg.gen    = RST_GENERAL;
                        next_cfg.clk    = RST_CLOCK;
                        next_cfg.pwr    = RST_POWER;
                        next_cfg.sr_tgl = ~cfg.sr_tgl;
                    end else begin
                        next_cfg.gen = wdata & WMASK_GENERAL;
                    end
                    next_cfg.commit_tgl = ~cfg.commit_tgl;
                end
                OFS_CLOCK: begin
                    next_cfg.clk = wdata & WMASK_CLOCK;
                    if (!scheme_legal(wr_scheme)) begin
                        next_cfg.clk[SCHEME_MSB:SCHEME_LSB] =
                            cfg.clk[SCHEME_MSB:SCHEME_LSB];
                    end
                    next_cfg.commit_tgl = ~cfg.commit_tgl;
                end
                OFS_POWER: begin
                    next_cfg.pwr        = wdata & WMASK_POWER;
                    next_cfg.commit_tgl = ~cfg.commit_tgl;
                end
                default: begin
                    next_cfg = cfg;
                end
            endcase
        end
    end

    // hardware reset acts without the serial clock, which may be stopped
    always_ff @(posedge SCLK_I or posedge RST_I) begin
        if (RST_I) begin
            cfg <= '{gen: RST_GENERAL, clk: RST_CLOCK, pwr: RST_POWER,
                     commit_tgl: 1'b0, sr_tgl: 1'b0};
        end else begin
            cfg <= next_cfg;
        end
    end

    // ==================================================
    // serial clock domain: read data, launched on the falling edge
    always_comb begin
        logic [7:0] rdata;
        logic       rbit;
        rdata    = read_reg(frame.instr[6:0], cfg);
        rbit     = rdata[bit_idx];
        next_drv = '0;
        if (read_phase) begin
            if (shared_line) begin
                next_drv.sdio    = rbit;
                next_drv.sdio_oe = 1'b1;
            end else begin
                next_drv.ser_out    = rbit;
                next_drv.ser_out_oe = 1'b1;
            end
        end
    end

    // deselect releases both data outputs at once
    always_ff @(negedge SCLK_I or posedge SEN_N_I) begin
        if (SEN_N_I) begin
            drv <= '0;
        end else begin
            drv <= next_drv;
        end
    end

    assign SDIO_O                   = drv.sdio;
    assign SDIO_OE_O                = drv.sdio_oe;
    assign SERIAL_DATA_OUT_PIN_O    = drv.ser_out;
    assign SERIAL_DATA_OUT_PIN_OE_O = drv.ser_out_oe;

    // ==================================================
    // crossing of write and soft reset events
    // toggles, not pulses, so no event is lost to the slow serial clock
    tgcr_sync u_commit_sync (
        .CLK_I   (CLK_I),
        .RST_I   (RST_I),
        .async_i (cfg.commit_tgl),
        .sync_o  (commit_sync)
    );

    tgcr_sync u_sr_sync (
        .CLK_I   (CLK_I),
        .RST_I   (RST_I),
        .async_i (cfg.sr_tgl),
        .sync_o  (sr_sync)
    );

    // ==================================================
    // core clock domain: applied settings
    // cfg words are read only after the synced toggle flags a finished write,
    // so they have been steady for several core cycles by then
    always_comb begin
        logic [2:0] pd_code;
        pd_code               = 3'h0;
        next_core             = core;
        next_core.commit_seen = commit_sync;
        next_core.sr_seen     = sr_sync;
        // one-cycle pulse per soft reset
        next_core.relock      = sr_sync ^ core.sr_seen;
        if (commit_sync != core.commit_seen) begin
            next_core.clk = cfg.clk;
            next_core.pwr = cfg.pwr;
        end
        next_core.scheme  = next_core.clk[SCHEME_MSB:SCHEME_LSB];
        next_core.en2     = next_core.clk[BIT_SECOND_CLK];
        next_core.inv2    = next_core.clk[BIT_SECOND_CLK] & FULL_DUPLEX_I;
        next_core.inv3    = next_core.clk[BIT_THIRD_INV];
        pd_code           = next_core.pwr[TXPD_MSB:TXPD_LSB];
        next_core.a_off   = (pd_code == TXPD_A_ONLY)
                         || (pd_code == TXPD_BOTH);
        next_core.b_off   = (pd_code == TXPD_B_ONLY)
                         || (pd_code == TXPD_BOTH);
        next_core.sup_off = pd_code == TXPD_BOTH;
        next_core.bias_on = 1'b1;
        if (RST_I) begin
            next_core         = '0;
            next_core.clk     = RST_CLOCK;
            next_core.pwr     = RST_POWER;
            next_core.bias_on = 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        core <= next_core;
    end

    assign CLK_SCHEME_O         = core.scheme;
    assign SECOND_PIN_CLK_EN_O  = core.en2;
    assign SECOND_PIN_CLK_INV_O = core.inv2;
    assign THIRD_PIN_CLK_INV_O  = core.inv3;
    assign TX_A_OUT_OFF_O       = core.a_off;
    assign TX_B_OUT_OFF_O       = core.b_off;
    assign TX_SUPPORT_OFF_O     = core.sup_off;
    assign DAC_BIAS_ON_O        = core.bias_on;
    assign PLL_RELOCK_O         = core.relock;
endmodule : tgcr_top

// File: tb/tgcr_top_chk.sv
`timescale 1ns/1ps
module tgcr_chk (
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    input  wire logic       SCLK_I,
    input  wire logic       SEN_N_I,
    input  wire logic       FULL_DUPLEX_I,
    input  wire logic       SDIO_OE_O,
    input  wire logic       SERIAL_DATA_OUT_PIN_OE_O,
    input  wire logic [2:0] CLK_SCHEME_O,
    input  wire logic       SECOND_PIN_CLK_EN_O,
    input  wire logic       SECOND_PIN_CLK_INV_O,
    input  wire logic       TX_A_OUT_OFF_O,
    input  wire logic       TX_B_OUT_OFF_O,
    input  wire logic       TX_SUPPORT_OFF_O,
    input  wire logic       DAC_BIAS_ON_O,
    input  wire logic       PLL_RELOCK_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_dup_clk;
        SECOND_PIN_CLK_EN_O && FULL_DUPLEX_I;
    endsequence
    sequence s_defaults;
        CLK_SCHEME_O == 3'h0 && !SECOND_PIN_CLK_EN_O && !TX_A_OUT_OFF_O;
    endsequence
    property p_bias; DAC_BIAS_ON_O; endproperty
    property p_sup; TX_SUPPORT_OFF_O |-> TX_A_OUT_OFF_O && TX_B_OUT_OFF_O; endproperty
    property p_scheme; !(CLK_SCHEME_O inside {3'h2, 3'h4, 3'h6}); endproperty
    property p_rst; $fell(RST_I) |-> s_defaults; endproperty
    property p_dupinv; s_dup_clk ##1 s_dup_clk |-> SECOND_PIN_CLK_INV_O; endproperty
    property p_oe; !(SDIO_OE_O && SERIAL_DATA_OUT_PIN_OE_O); endproperty
    property p_pulse; PLL_RELOCK_O |=> !PLL_RELOCK_O; endproperty
    property p_relock; PLL_RELOCK_O |-> ##[0:6] s_defaults; endproperty
    property p_commit; $changed(CLK_SCHEME_O) |-> SCLK_I && !SEN_N_I; endproperty
    a_bias:   assert property (p_bias) else $error("bias dropped");
    a_sup:    assert property (p_sup) else $error("support off alone");
    a_scheme: assert property (p_scheme) else $error("unused scheme applied");
    a_rst:    assert property (p_rst) else $error("bad reset defaults");
    a_dupinv: assert property (p_dupinv) else $error("second clock not inverted");
    a_oe:     assert property (p_oe) else $error("both data outputs driven");
    a_pulse:  assert property (p_pulse) else $error("relock pulse too long");
    a_relock: assert property (p_relock) else $error("defaults not restored");
    a_commit: assert property (p_commit) else $error("scheme changed off commit");
endmodule : tgcr_chk
bind tgcr_top tgcr_chk i_chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .SCLK_I(SCLK_I), .SEN_N_I(SEN_N_I),
    .FULL_DUPLEX_I(FULL_DUPLEX_I), .SDIO_OE_O(SDIO_OE_O),
    .SERIAL_DATA_OUT_PIN_OE_O(SERIAL_DATA_OUT_PIN_OE_O),
    .CLK_SCHEME_O(CLK_SCHEME_O), .SECOND_PIN_CLK_EN_O(SECOND_PIN_CLK_EN_O),
    .SECOND_PIN_CLK_INV_O(SECOND_PIN_CLK_INV_O), .TX_A_OUT_OFF_O(TX_A_OUT_OFF_O),
    .TX_B_OUT_OFF_O(TX_B_OUT_OFF_O), .TX_SUPPORT_OFF_O(TX_SUPPORT_OFF_O),
    .DAC_BIAS_ON_O(DAC_BIAS_ON_O), .PLL_RELOCK_O(PLL_RELOCK_O)
);

// File: tb/tgcr_host.sv
`timescale 1ns/1ps
module tgcr_host import tgcr_pkg::*; (
    output logic       sclk_o,
    output logic       sen_n_o,
    output logic       sdio_o,
    input  wire logic  line_i,
    input  wire logic  ser_out_i,
    output logic [7:0] rd_o,
    output logic       done_o
);
    logic shared = 1'b0;
    logic lsb = 1'b0;
    initial begin
        sclk_o = 1'b0;
        sen_n_o = 1'b0;
        sdio_o = 1'b0;
        rd_o = 8'h00;
        done_o = 1'b0;
        // late rising deselect clears the frame logic
        #1 sen_n_o = 1'b1;
    end
    // ====
    // one frame, clock stands still outside it
    task automatic frame(input logic [7:0] ins, input logic [7:0] dat);
        logic [15:0] w;
        int          x;
        w = {ins, dat};
        #13 sen_n_o = 1'b0;
        for (int i = 0; i < 16; i++) begin
            x = lsb ? (i < 8 ? i + 8 : i - 8) : 15 - i;
            if (i > 7 && ins[7] && shared) sdio_o = ~sdio_o;
            else sdio_o = w[x];
            #40 sclk_o = 1'b1;
            if (i > 7) rd_o[x] = shared ? line_i : ser_out_i;
            #80 sclk_o = 1'b0;
            #40;
        end
        sen_n_o = 1'b1;
        if (!ins[7] && ins[6:0] == OFS_GENERAL) begin
            shared = dat[BIT_SHARED_LINE] & ~dat[BIT_SOFT_RESET];
            lsb = dat[BIT_LSB_FIRST] & ~dat[BIT_SOFT_RESET];
        end
        done_o = ins[7];
        #80 done_o = 1'b0;
        #80;
    endtask : frame
endmodule : tgcr_host

// File: tb/transceiver_general_config_regs_tb_top.sv
`timescale 1ns/1ps
module transceiver_general_config_regs_tb_top import tgcr_pkg::*;;
    logic       clk, rst, dup, sclk, sen_n, hdrv, sdio_o, sdio_oe, ser_out, ser_out_oe, done;
    logic       en2, inv2, inv3, txa, txb, sup, bias, relock;
    logic [2:0] scheme;
    logic [7:0] rd;
    logic [7:0] npulse = 8'h00;
    logic [7:0] q[$];
    int         n_errors = 0;
    int         checks = 0;
    int         cyc = 0;
    wire        line_w = sdio_oe ? sdio_o : hdrv;
    tgcr_top i_dut (
        .CLK_I(clk), .RST_I(rst), .SCLK_I(sclk), .SEN_N_I(sen_n), .SDIO_I(line_w),
        .SDIO_O(sdio_o), .SDIO_OE_O(sdio_oe), .SERIAL_DATA_OUT_PIN_O(ser_out),
        .SERIAL_DATA_OUT_PIN_OE_O(ser_out_oe), .FULL_DUPLEX_I(dup),
        .CLK_SCHEME_O(scheme), .SECOND_PIN_CLK_EN_O(en2),
        .SECOND_PIN_CLK_INV_O(inv2), .THIRD_PIN_CLK_INV_O(inv3), .TX_A_OUT_OFF_O(txa),
        .TX_B_OUT_OFF_O(txb), .TX_SUPPORT_OFF_O(sup), .DAC_BIAS_ON_O(bias),
        .PLL_RELOCK_O(relock)
    );
    tgcr_host i_host (
        .sclk_o(sclk), .sen_n_o(sen_n), .sdio_o(hdrv), .line_i(line_w), .ser_out_i(ser_out),
        .rd_o(rd), .done_o(done)
    );
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_host.frame({1'b0, a}, d);
    endtask : wr
    task automatic rd_exp(input logic [6:0] a, input logic [7:0] e);
        q.push_back(e);
        i_host.frame({1'b1, a}, 8'h00);
    endtask : rd_exp
    always @(posedge done) chk("read", q.pop_front(), rd);
    always @(posedge clk) begin
        if (relock) npulse <= npulse + 8'h01;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            close_out();
        end
    end
    // ====
    // main sequence
    initial begin
        logic [7:0] dc, dp;
        logic [2:0] cur;
        logic [2:0] pc[4];
        pc = '{3'h4, 3'h2, 3'h7, 3'h0};
        rst = 1'b0;
        dup = 1'b0;
        void'($urandom(90873));
        // late rising edge so the serial-side asynchronous clear is seen
        #1 rst = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd_exp(OFS_GENERAL, RST_GENERAL);
        rd_exp(OFS_CLOCK, RST_CLOCK);
        rd_exp(OFS_POWER, RST_POWER);
        cur = 3'h0;
        for (int c = 0; c < 8; c++) begin
            dc = 8'($urandom);
            dc[7:5] = c[2:0];
            @(posedge clk);
            dup <= dc[0];
            wr(OFS_CLOCK, dc);
            if (c inside {0, 1, 3, 5, 7}) cur = c[2:0];
            dc = {cur, dc[4:0] & 5'h06};
            rd_exp(OFS_CLOCK, dc);
            chk("scheme", {5'h00, cur}, {5'h00, scheme});
            chk("clk_pins", {6'h00, dc[2:1]}, {6'h00, en2, inv3});
            chk("inv2", {7'h00, dc[2] & dup}, {7'h00, inv2});
        end
        foreach (pc[k]) begin
            dp = 8'($urandom);
            dp[7:5] = pc[k];
            wr(OFS_POWER, dp);
            rd_exp(OFS_POWER, dp);
            chk("tx_off", {4'h0, pc[k][2:1], &pc[k], 1'b1}, {4'h0, txa, txb, sup, bias});
        end
        wr(7'h05, 8'hFF);
        rd_exp(7'h05, 8'h00);
        rd_exp(OFS_POWER, dp);
        wr(OFS_GENERAL, 8'h40);
        rd_exp(OFS_GENERAL, 8'h40);
        rd_exp(OFS_CLOCK, dc);
        wr(OFS_GENERAL, 8'hC0);
        rd_exp(OFS_CLOCK, dc);
        rd_exp(OFS_GENERAL, 8'hC0);
        chk("relock", 8'h00, npulse);
        wr(OFS_GENERAL, 8'hE0);
        chk("relock", 8'h01, npulse);
        rd_exp(OFS_GENERAL, RST_GENERAL);
        rd_exp(OFS_CLOCK, RST_CLOCK);
        rd_exp(OFS_POWER, RST_POWER);
        chk("scheme", 8'h00, {5'h00, scheme});
        close_out();
    end
endmodule : transceiver_general_config_regs_tb_top
